// *** tcs_pkg.sv ***
package tcs_pkg;
  // Time base.
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS_DEF = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned EXT_STEP_MS = 10;
  // Sizes.
  localparam int NCMD = 4;
  localparam int NCMD_TONE = 2;
  localparam int VW = 16;
  localparam int NREL = 17;
  localparam int NSRC = 8;
  localparam int RPW = 4;
  localparam int NMASKW = 5;
  localparam int NCNT = 8;
  localparam int CW = 12;
  localparam int DW = 4;
  localparam int WSH = 2;
  // Register offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_VOTE = 8'h04;
  localparam logic [7:0] A_TIME = 8'h08;
  localparam logic [7:0] A_LONG = 8'h0C;
  localparam logic [7:0] A_TONE = 8'h10;
  localparam logic [7:0] A_IDENT = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_CCLR = 8'h1C;
  localparam logic [7:0] A_CNT = 8'h20;
  localparam logic [7:0] A_MASK = 8'h30;
  localparam logic [7:0] A_RCFG = 8'h44;
  localparam logic [7:0] A_RELAY = 8'h48;
  // Write masks and reset values.
  localparam logic [31:0] CTRL_WM = 32'h0000_03FF;
  localparam logic [31:0] VOTE_WM = 32'h0000_1F1F;
  localparam logic [31:0] VOTE_RST = 32'h0000_0804;
  localparam logic [31:0] TIME_WM = 32'h007F_7F7F;
  localparam logic [31:0] LONG_WM = 32'h0000_FFFF;
  localparam logic [31:0] TONE_WM = 32'hFF7F_7F7F;
  localparam logic [31:0] IDENT_WM = 32'h00FF_FFFF;
  localparam logic [31:0] RCFG_WM = 32'hFF01_FFFF;
  localparam logic [13:0] PIN_RST = 14'h0F00;
  localparam logic [6:0] SAT7 = 7'h7F;
  localparam logic [7:0] SAT8 = 8'hFF;
  localparam logic [10:0] SAT11 = 11'h7FF;
  localparam logic [7:0] VER_SUFFIX = 8'h99;
  localparam logic [7:0] THR_FULL = 8'hFF;
  localparam logic [7:0] KNOWN_OPS = 8'h10;
  // Modes and states.
  typedef enum logic [1:0] {DIG_CONTRA = 2'h0, DIG_SLAVE_CO = 2'h1, DIG_MASTER_CO = 2'h2,
    DIG_LOOP = 2'h3} tcs_dig_mode_t;
  typedef enum logic [1:0] {TONE_NORMAL = 2'h0, TONE_ALOOP = 2'h1, TONE_DLOOP = 2'h2,
    TONE_SPARE = 2'h3} tcs_tone_mode_t;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_ACTIVE = 3'b010,
    ST_HOLD = 3'b100} tcs_state_t;
  // Register layouts.
  typedef struct packed {logic [21:0] rsv; logic dual; logic hyst; logic alone; logic itg;
    logic id_en; tcs_tone_mode_t tmode; tcs_dig_mode_t dig; logic tone;} tcs_ctrl_t;
  typedef struct packed {logic [18:0] r1; logic [4:0] m; logic [2:0] r0;
    logic [4:0] n;} tcs_vote_t;
  typedef struct packed {logic [8:0] r2; logic [6:0] out_ext; logic r1; logic [6:0] in_ext;
    logic r0; logic [6:0] deb;} tcs_time_t;
  typedef struct packed {logic [15:0] rsv; logic [7:0] cut; logic [7:0] hold;} tcs_long_t;
  typedef struct packed {logic [7:0] corr; logic r2; logic [6:0] inh_ext; logic r1;
    logic [6:0] onset; logic r0; logic [6:0] qual;} tcs_tone_t;
  typedef struct packed {logic [7:0] rsv; logic [7:0] major; logic [15:0] code;} tcs_ident_t;
  typedef struct packed {logic [7:0] delay; logic [6:0] rsv; logic [16:0] latch;} tcs_rcfg_t;
  typedef struct packed {logic [7:0] major; logic [7:0] minor;} tcs_ver_t;
  typedef struct packed {tcs_ver_t adj; logic [1:0] rsv; logic cut; logic susp; logic inh;
    logic refused; logic vermm; logic idok; logic [3:0] fault; logic [3:0] trip;} tcs_stat_t;
  // Carriers.
  typedef struct packed {logic deep; logic eq; logic [3:0] fb_bn; logic [3:0] fb_a;
    logic [3:0] trip;} tcs_pin_t;
  typedef struct packed {logic sample; logic [1:0] trip;} tcs_tone_in_t;
  typedef struct packed {logic tone; tcs_dig_mode_t dig; tcs_tone_mode_t tmode;} tcs_link_t;
endpackage : tcs_pkg

// *** tcs_top.sv ***
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
// Summary of operation
// - Trip input accepted after debounce time.
// - Each command carried on complementary paths.
// - Trip only when both paths agree.
// - Continuous self-test flags path failures.
// - Matching pass codes gate command operation.
// - Uninterpretable peer request reported, not executed.
// - Newer processor version becomes monitor major.99.
// - Major version mismatch only reported.
// - Digital command valid: N of M frames.
// - Tone command valid: N of M samples.
// - Discriminator threshold scales with N over M.
// - Tone output options and tone timers.
// - Tone inhibit and suspend on noise.
// - Eight three-digit trip counters.
// - Any alarm source routable to relays.
// - Relay on-delay, latching or self-resetting.
// - Per-command debounce and extend timers.
// - Shared cut-off and hold-off timers.
// - Four digital or two tone commands.
// - Digital link modes selectable.
// - Tone link modes selectable.
// - Trip blocked during inhibit extend.
module tcs_top #(
  parameter int unsigned CYC_PER_MS = tcs_pkg::CYC_PER_MS_DEF
) (
  // Clock and reset.
  input logic pclk,
  input logic presetn,
  // APB slave.
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trip inputs and transmit commands.
  input logic [3:0] trip_in,
  output logic [3:0] tx_cmd,
  // Received link data.
  input logic rx_frame,
  input logic [3:0] rx_cmd,
  input tcs_pkg::tcs_tone_in_t tone_in,
  input logic snr_equal,
  input logic snr_deep,
  // Identity, version and peer requests.
  input logic [15:0] remote_code,
  input logic [7:0] remote_major,
  input tcs_pkg::tcs_ver_t proc_ver,
  input logic peer_req,
  input logic [7:0] peer_op,
  output logic req_exec,
  output tcs_pkg::tcs_ver_t proc_ver_adj,
  // Redundant trip outputs and their feedback.
  output logic [3:0] trip_a,
  output logic [3:0] trip_b_n,
  input logic [3:0] fb_a,
  input logic [3:0] fb_b_n,
  // Configuration outputs and alarm relays.
  output logic [7:0] disc_thr,
  output tcs_pkg::tcs_link_t link_cfg,
  output logic [16:0] relay
);
  import tcs_pkg::*;

  // Pick a window mask of the newest m samples.
  function automatic logic [VW-1:0] win_mask(input logic [4:0] m);
    logic [VW:0] t;
    t = (17'h00001 << m) - 17'h00001;
    return t[VW-1:0];
  endfunction : win_mask

  // Count ones in a vote history.
  function automatic logic [4:0] popcnt(input logic [VW-1:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int k = 0; k < VW; k++) begin
      c = c + 5'(v[k]);
    end
    return c;
  endfunction : popcnt

  // Increment a three-digit decimal count, wrapping after 999.
  function automatic logic [CW-1:0] bcd_inc(input logic [CW-1:0] v);
    logic [CW-1:0] r;
    logic cy;
    r = v;
    cy = 1'b1;
    for (int k = 0; k < CW / DW; k++) begin
      if (cy) begin
        if (r[k*DW +: DW] == 4'h9) begin
          r[k*DW +: DW] = 4'h0;
        end else begin
          r[k*DW +: DW] = r[k*DW +: DW] + 4'h1;
          cy = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_inc

  // Byte address hits one word of a register block.
  function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base, input int n);
    return (a >= base) && (a < 8'(base + 8'(n << WSH))) && (a[WSH-1:0] == 2'h0);
  endfunction : in_blk

  // Pin synchronisers; only the second stage is read.
  tcs_pin_t pin_raw;
  tcs_pin_t pin_s1_q;
  tcs_pin_t pin_q;
  assign pin_raw = '{deep: snr_deep, eq: snr_equal, fb_bn: fb_b_n, fb_a: fb_a, trip: trip_in};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= PIN_RST;
      pin_q <= PIN_RST;
    end else begin
      pin_s1_q <= pin_raw;
      pin_q <= pin_s1_q;
    end
  end

  // Millisecond and second ticks.
  logic [15:0] pre_q, pre_d;
  logic [9:0] msc_q, msc_d;
  logic tick_ms, tick_s;
  assign tick_ms = (pre_q == 16'(CYC_PER_MS - 1));
  assign tick_s = tick_ms && (msc_q == 10'(MS_PER_S - 1));
  always_comb begin
    pre_d = tick_ms ? 16'h0000 : pre_q + 16'h0001;
    msc_d = tick_s ? 10'h000 : (tick_ms ? msc_q + 10'h001 : msc_q);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      msc_q <= '0;
    end else begin
      pre_q <= pre_d;
      msc_q <= msc_d;
    end
  end

  // Bus strobes; the slave answers in the first access cycle.
  logic wr;
  tcs_stat_t wstat;
  assign wr = psel && penable && pwrite && (paddr[WSH-1:0] == 2'h0);
  assign wstat = tcs_stat_t'(pwdata);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !((paddr[WSH-1:0] == 2'h0) && (paddr <= A_RELAY));

  // Configuration registers written by software.
  tcs_ctrl_t ctrl_q, ctrl_d;
  tcs_vote_t vote_q, vote_d;
  tcs_time_t time_q, time_d;
  tcs_long_t long_q, long_d;
  tcs_tone_t tone_q, tone_d;
  tcs_ident_t ident_q, ident_d;
  tcs_rcfg_t rcfg_q, rcfg_d;
  logic [NMASKW-1:0][31:0] mask_q, mask_d;
  always_comb begin
    ctrl_d = ctrl_q;
    vote_d = vote_q;
    time_d = time_q;
    long_d = long_q;
    tone_d = tone_q;
    ident_d = ident_q;
    rcfg_d = rcfg_q;
    mask_d = mask_q;
    if (wr) begin
      if (paddr == A_CTRL) ctrl_d = tcs_ctrl_t'(pwdata & CTRL_WM);
      if (paddr == A_VOTE) vote_d = tcs_vote_t'(pwdata & VOTE_WM);
      if (paddr == A_TIME) time_d = tcs_time_t'(pwdata & TIME_WM);
      if (paddr == A_LONG) long_d = tcs_long_t'(pwdata & LONG_WM);
      if (paddr == A_TONE) tone_d = tcs_tone_t'(pwdata & TONE_WM);
      if (paddr == A_IDENT) ident_d = tcs_ident_t'(pwdata & IDENT_WM);
      if (paddr == A_RCFG) rcfg_d = tcs_rcfg_t'(pwdata & RCFG_WM);
      if (in_blk(paddr, A_MASK, NMASKW)) mask_d[3'(8'(paddr - A_MASK) >> WSH)] = pwdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      vote_q <= tcs_vote_t'(VOTE_RST);
      time_q <= '0;
      long_q <= '0;
      tone_q <= '0;
      ident_q <= '0;
      rcfg_q <= '0;
      mask_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      vote_q <= vote_d;
      time_q <= time_d;
      long_q <= long_d;
      tone_q <= tone_d;
      ident_q <= ident_d;
      rcfg_q <= rcfg_d;
      mask_q <= mask_d;
    end
  end

  // Effective N and M, clamped to 1..M and 1..16.
  logic [4:0] m_eff, n_eff;
  logic [10:0] in_lim, out_lim;
  always_comb begin
    m_eff = (vote_q.m == 5'h00) ? 5'h01 : ((vote_q.m > 5'(VW)) ? 5'(VW) : vote_q.m);
    n_eff = (vote_q.n == 5'h00) ? 5'h01 : ((vote_q.n > m_eff) ? m_eff : vote_q.n);
    in_lim = 11'(time_q.in_ext * EXT_STEP_MS);
    out_lim = 11'(time_q.out_ext * EXT_STEP_MS);
  end

  // Noise inhibit; extend counter starts saturated so reset raises no inhibit.
  logic [6:0] onset_q, onset_d, iext_q, iext_d;
  logic inh_src, inhibit, suspend, id_ok, permit;
  logic [7:0] corr_q, corr_d;
  tcs_state_t st_q, st_d;
  assign inh_src = ctrl_q.tone && pin_q.eq && (onset_q >= tone_q.onset);
  assign inhibit = inh_src || (ctrl_q.tone && (iext_q < tone_q.inh_ext));
  assign suspend = ctrl_q.tone && pin_q.deep;
  assign id_ok = !ctrl_q.id_en || (remote_code == ident_q.code);
  assign permit = id_ok && !inhibit && !suspend && (st_q != ST_HOLD);
  always_comb begin
    onset_d = !pin_q.eq ? 7'h00 : ((tick_ms && onset_q != SAT7) ? onset_q + 7'h01 : onset_q);
    iext_d = inh_src ? 7'h00 : ((tick_ms && iext_q != SAT7) ? iext_q + 7'h01 : iext_q);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onset_q <= '0;
      iext_q <= SAT7;
    end else begin
      onset_q <= onset_d;
      iext_q <= iext_d;
    end
  end

  // Per-command paths.
  logic strobe;
  logic [NCMD-1:0] smp, qual_ok, rxc, rx_ext, cmd, fault_q, tx_q, ta_q, tbn_q;
  logic corr_ok;
  assign strobe = ctrl_q.tone ? tone_in.sample : rx_frame;
  assign smp = ctrl_q.tone ? NCMD'(tone_in.trip) : rx_cmd;
  assign corr_ok = corr_q <= tone_q.corr;
  always_comb begin
    rxc = qual_ok;
    if (ctrl_q.tone) begin
      rxc = ctrl_q.dual ? NCMD'(&qual_ok[NCMD_TONE-1:0] & corr_ok) :
        NCMD'(qual_ok[NCMD_TONE-1:0]);
    end
  end
  assign cmd = rx_ext & {NCMD{permit}};
  assign tx_cmd = tx_q;
  assign trip_a = ta_q;
  assign trip_b_n = tbn_q;

  for (genvar i = 0; i < NCMD; i++) begin : g_cmd
    logic [VW-1:0] hist_q, hist_d;
    logic vote_q, vote_d, a_q, a_d, bn_q, bn_d, ta_d, tbn_d, f_d, tx_d, acc;
    logic [1:0] pa_q, pb_q;
    logic [6:0] qc_q, qc_d, dc_q, dc_d;
    logic [10:0] oc_q, oc_d, ic_q, ic_d;
    // Voting, qualifying, extend and debounce counters, then the two paths.
    always_comb begin
      logic [4:0] cnt;
      cnt = popcnt((strobe ? {hist_q[VW-2:0], smp[i]} : hist_q) & win_mask(m_eff));
      hist_d = hist_q;
      vote_d = vote_q;
      if (suspend) begin
        hist_d = '0;
        vote_d = 1'b0;
      end else if (strobe) begin
        hist_d = {hist_q[VW-2:0], smp[i] && !(inhibit && ctrl_q.itg)};
        cnt = popcnt(hist_d & win_mask(m_eff));
        vote_d = (cnt >= n_eff) || (ctrl_q.tone && ctrl_q.hyst && vote_q &&
          (n_eff > 5'h01) && (cnt >= n_eff - 5'h01));
      end
      if (ctrl_q.tone && ctrl_q.alone && inhibit) vote_d = vote_q;
      qc_d = !vote_q ? 7'h00 : ((tick_ms && qc_q != SAT7) ? qc_q + 7'h01 : qc_q);
      oc_d = rxc[i] ? 11'h000 : ((tick_ms && oc_q != SAT11) ? oc_q + 11'h001 : oc_q);
      dc_d = !pin_q.trip[i] ? 7'h00 : ((tick_ms && dc_q != SAT7) ? dc_q + 7'h01 : dc_q);
      acc = pin_q.trip[i] && (dc_q >= time_q.deb);
      ic_d = acc ? 11'h000 : ((tick_ms && ic_q != SAT11) ? ic_q + 11'h001 : ic_q);
      tx_d = (acc || (ic_q < in_lim)) && (!ctrl_q.tone || (i < NCMD_TONE));
      a_d = cmd[i];
      bn_d = !cmd[i];
      ta_d = a_q && !bn_q && !fault_q[i];
      tbn_d = bn_q || !a_q || fault_q[i];
      f_d = (fault_q[i] && !(wr && paddr == A_STAT && wstat.fault[i])) ||
        (a_q == bn_q) || (pin_q.fb_a[i] != pa_q[1]) || (pin_q.fb_bn[i] != pb_q[1]);
    end
    assign qual_ok[i] = vote_q && (!ctrl_q.tone || (qc_q >= tone_q.qual));
    assign rx_ext[i] = rxc[i] || (oc_q < out_lim);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hist_q <= '0;
        vote_q <= 1'b0;
        qc_q <= '0;
        oc_q <= SAT11;
        dc_q <= '0;
        ic_q <= SAT11;
        tx_q[i] <= 1'b0;
        a_q <= 1'b0;
        bn_q <= 1'b1;
        ta_q[i] <= 1'b0;
        tbn_q[i] <= 1'b1;
        pa_q <= 2'b00;
        pb_q <= 2'b11;
        fault_q[i] <= 1'b0;
      end else begin
        hist_q <= hist_d;
        vote_q <= vote_d;
        qc_q <= qc_d;
        oc_q <= oc_d;
        dc_q <= dc_d;
        ic_q <= ic_d;
        tx_q[i] <= tx_d;
        a_q <= a_d;
        bn_q <= bn_d;
        ta_q[i] <= ta_d;
        tbn_q[i] <= tbn_d;
        pa_q <= {pa_q[0], ta_q[i]};
        pb_q <= {pb_q[0], tbn_q[i]};
        fault_q[i] <= f_d;
      end
    end
  end

  // Correlation window and the shared cut-off / hold-off sequencer.
  logic [7:0] sec_q, sec_d;
  always_comb begin
    corr_d = corr_q;
    if (!(|qual_ok[NCMD_TONE-1:0])) corr_d = 8'h00;
    else if (!(&qual_ok[NCMD_TONE-1:0]) && tick_ms && corr_q != SAT8) corr_d = corr_q + 8'h01;
    st_d = st_q;
    sec_d = (tick_s && sec_q != SAT8) ? sec_q + 8'h01 : sec_q;
    unique case (st_q)
      ST_IDLE: begin
        sec_d = 8'h00;
        if (|rx_ext) st_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (!(|rx_ext)) begin
          st_d = ST_IDLE;
        end else if ((long_q.cut != 8'h00) && (sec_q >= long_q.cut)) begin
          st_d = ST_HOLD;
          sec_d = 8'h00;
        end
      end
      ST_HOLD: begin
        if ((sec_q >= long_q.hold) && !(|rx_ext)) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_q <= '0;
      st_q <= ST_IDLE;
      sec_q <= '0;
    end else begin
      corr_q <= corr_d;
      st_q <= st_d;
      sec_q <= sec_d;
    end
  end

  // Trip counters: sent on commands 0..3, received on 4..7.
  logic [NCNT-1:0][CW-1:0] cnt_q, cnt_d;
  logic [NCMD-1:0] txp_q, tap_q;
  always_comb begin
    cnt_d = (wr && paddr == A_CCLR) ? '0 : cnt_q;
    for (int k = 0; k < NCMD; k++) begin
      if (tx_q[k] && !txp_q[k]) cnt_d[k] = bcd_inc(cnt_d[k]);
      if (ta_q[k] && !tap_q[k]) cnt_d[NCMD+k] = bcd_inc(cnt_d[NCMD+k]);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      txp_q <= '0;
      tap_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      txp_q <= tx_q;
      tap_q <= ta_q;
    end
  end

  // Versions, peer requests and discriminator threshold.
  logic refused_q, refused_d, exec_q, exec_d, vermm;
  tcs_ver_t adj_q, adj_d;
  logic [7:0] thr_q, thr_d;
  assign vermm = remote_major != ident_q.major;
  always_comb begin
    adj_d = (proc_ver.major > ident_q.major) ?
      tcs_ver_t'{major: ident_q.major, minor: VER_SUFFIX} : proc_ver;
    refused_d = (refused_q && !(wr && paddr == A_STAT && wstat.refused)) ||
      (peer_req && (peer_op >= KNOWN_OPS));
    exec_d = peer_req && (peer_op < KNOWN_OPS) && id_ok;
    thr_d = 8'((13'(n_eff) * 13'(THR_FULL)) / 13'(m_eff));
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adj_q <= '0;
      refused_q <= 1'b0;
      exec_q <= 1'b0;
      thr_q <= '0;
    end else begin
      adj_q <= adj_d;
      refused_q <= refused_d;
      exec_q <= exec_d;
      thr_q <= thr_d;
    end
  end
  assign proc_ver_adj = adj_q;
  assign req_exec = exec_q;
  assign disc_thr = thr_q;
  assign link_cfg = '{tone: ctrl_q.tone, dig: ctrl_q.dig, tmode: ctrl_q.tmode};

  // Alarm relays: routed sources, on-delay and optional latch.
  logic [NSRC-1:0] src;
  logic [NREL-1:0] rel_q;
  assign src = {|ta_q, st_q == ST_HOLD, suspend, inhibit, refused_q, vermm, !id_ok, |fault_q};
  assign relay = rel_q;
  for (genvar r = 0; r < NREL; r++) begin : g_rel
    logic [7:0] dly_q, dly_d;
    logic raw, rel_d;
    always_comb begin
      raw = |(src & mask_q[r / RPW][(r % RPW) * NSRC +: NSRC]);
      dly_d = !raw ? 8'h00 : ((tick_ms && dly_q != SAT8) ? dly_q + 8'h01 : dly_q);
      rel_d = (raw && (dly_q >= rcfg_q.delay)) ||
        (rel_q[r] && rcfg_q.latch[r] && !(wr && paddr == A_RELAY && pwdata[r]));
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dly_q <= '0;
        rel_q[r] <= 1'b0;
      end else begin
        dly_q <= dly_d;
        rel_q[r] <= rel_d;
      end
    end
  end

  // Read data, captured in the setup cycle.
  logic [31:0] rd_q, rd_d;
  logic [1:0] ci;
  tcs_stat_t st_w;
  assign prdata = rd_q;
  assign ci = 2'(8'(paddr - A_CNT) >> WSH);
  always_comb begin
    st_w = '{adj: adj_q, rsv: 2'b00, cut: st_q == ST_HOLD, susp: suspend, inh: inhibit,
      refused: refused_q, vermm: vermm, idok: id_ok, fault: fault_q, trip: ta_q};
    rd_d = rd_q;
    if (psel && !penable) begin
      rd_d = 32'h0000_0000;
      if (paddr == A_CTRL) rd_d = ctrl_q;
      if (paddr == A_VOTE) rd_d = vote_q;
      if (paddr == A_TIME) rd_d = time_q;
      if (paddr == A_LONG) rd_d = long_q;
      if (paddr == A_TONE) rd_d = tone_q;
      if (paddr == A_IDENT) rd_d = ident_q;
      if (paddr == A_STAT) rd_d = st_w;
      if (paddr == A_CCLR) rd_d = 32'(thr_q);
      if (in_blk(paddr, A_CNT, NCNT / 2)) rd_d = {4'h0, cnt_q[2*ci+1], 4'h0, cnt_q[2*ci]};
      if (in_blk(paddr, A_MASK, NMASKW)) rd_d = mask_q[3'(8'(paddr - A_MASK) >> WSH)];
      if (paddr == A_RCFG) rd_d = rcfg_q;
      if (paddr == A_RELAY) rd_d = 32'(rel_q);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end
endmodule : tcs_top

// *** tcs_monitor.sv ***
`timescale 1ns/10ps
// Port checker for the trip command paths, peer requests and versions.
module tcs_monitor
  import tcs_pkg::*;
(
  // Clock, reset and bus strobes.
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  // Command paths.
  input logic [3:0] trip_in,
  input logic [3:0] tx_cmd,
  input logic rx_frame,
  input tcs_pkg::tcs_tone_in_t tone_in,
  input logic [3:0] trip_a,
  input logic [3:0] trip_b_n,
  input logic [3:0] fb_a,
  input logic [7:0] disc_thr,
  // Peer requests and versions.
  input logic peer_req,
  input logic [7:0] peer_op,
  input logic req_exec,
  input tcs_pkg::tcs_ver_t proc_ver,
  input tcs_pkg::tcs_ver_t proc_ver_adj
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A completed bus write.
  logic wr;
  assign wr = psel && penable && pwrite;
  paths_compl_a: assert property (trip_a == ~trip_b_n)
    else $error("paths disagree");
  trip_delay_a: assert property ($rose(trip_a[0]) |-> $past(rx_frame, 3)
    || $past(tone_in.sample, 3)) else $error("trip without strobe");
  deb_min_a: assert property ((tx_cmd & ~$past(tx_cmd)
    & ~($past(trip_in) & $past(trip_in, 2))) == 4'h0) else $error("send too early");
  exec_known_a: assert property (req_exec |-> $past(peer_req)
    && $past(peer_op) < KNOWN_OPS) else $error("bad execute");
  refuse_op_a: assert property (peer_req && peer_op >= KNOWN_OPS |=> !req_exec)
    else $error("unknown op ran");
  ver_adj_a: assert property (proc_ver_adj != $past(proc_ver) |->
    proc_ver_adj.minor == VER_SUFFIX && proc_ver_adj.major < $past(proc_ver.major))
    else $error("bad version");
  thr_write_a: assert property (!$stable(disc_thr) |-> $past(wr) || $past(wr, 2)
    || $past(wr, 3) || !$past(presetn, 2)) else $error("threshold moved");
  fault_guard_a: assert property ((trip_a[0] && !fb_a[0]) [*2] |-> ##[0:3] !trip_a[0])
    else $error("fault not guarded");
endmodule : tcs_monitor
bind tcs_top tcs_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .trip_in(trip_in), .tx_cmd(tx_cmd),
  .rx_frame(rx_frame), .tone_in(tone_in), .trip_a(trip_a), .trip_b_n(trip_b_n),
  .fb_a(fb_a), .disc_thr(disc_thr), .peer_req(peer_req), .peer_op(peer_op),
  .req_exec(req_exec), .proc_ver(proc_ver), .proc_ver_adj(proc_ver_adj));

// *** tcs_remote.sv ***
`timescale 1ns/10ps
// Far terminal: sends one frame per request and shows its identity.
module tcs_remote #(
  parameter logic [7:0] MAJOR = 8'h05
) (
  // Clock.
  input logic pclk,
  // Requests from the bench.
  input logic go,
  input logic [3:0] cmd,
  input logic [15:0] code,
  // Link side.
  output logic rx_frame,
  output logic [3:0] rx_cmd,
  output logic [15:0] remote_code,
  output logic [7:0] remote_major
);
  // Frames last one cycle; outside them the bits invert so stale data never looks valid.
  always_ff @(posedge pclk) begin
    rx_frame <= go;
    rx_cmd <= go ? cmd : ~cmd;
  end
  // Pass code and major version as the far monitor reports them.
  assign remote_code = code;
  assign remote_major = MAJOR;
endmodule : tcs_remote

// *** tcs_top_test.sv ***
`timescale 1ns/10ps
// Bench: bus and frame tasks, then sequences of calls with expected values.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tcs_top_test;
  import tcs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, stuck = 0, err;
  logic peer_req = 0, pready, pslverr, req_exec, rx_frame;
  logic [7:0] paddr = 0, peer_op = 0, remote_major, disc_thr;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] trip_in = 0, cmd = 0, tx_cmd, rx_cmd, trip_a, trip_b_n;
  logic [15:0] code = 16'h0000, remote_code;
  tcs_ver_t proc_ver = 16'h0000, proc_ver_adj;
  tcs_link_t link_cfg;
  tcs_tone_in_t tone = 3'h0;
  logic [16:0] relay;
  int fails = 0, check_count = 0, cyc = 0;
  // Feedback mirrors the outputs unless a stuck path is injected.
  wire [3:0] fb_a = trip_a & ~{3'h0, stuck};
  wire [3:0] fb_b_n = trip_b_n;
  always #25 pclk = ~pclk;
  tcs_top #(.CYC_PER_MS(20)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trip_in(trip_in), .tx_cmd(tx_cmd), .rx_frame(rx_frame),
    .rx_cmd(rx_cmd), .tone_in(tone), .snr_equal(1'b0), .snr_deep(1'b0),
    .remote_code(remote_code), .remote_major(remote_major), .proc_ver(proc_ver),
    .peer_req(peer_req), .peer_op(peer_op), .req_exec(req_exec),
    .proc_ver_adj(proc_ver_adj), .trip_a(trip_a), .trip_b_n(trip_b_n), .fb_a(fb_a),
    .fb_b_n(fb_b_n), .disc_thr(disc_thr), .link_cfg(link_cfg), .relay(relay));
  tcs_remote u_rem (.pclk(pclk), .go(go), .cmd(cmd), .code(code), .rx_frame(rx_frame),
    .rx_cmd(rx_cmd), .remote_code(remote_code), .remote_major(remote_major));
  // One bus transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One frame from the far end, then time for the output to settle.
  task automatic frame(input logic [3:0] c);
    @(posedge pclk);
    go <= 1'b1;
    cmd <= c;
    @(posedge pclk);
    go <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : frame
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Cuts a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_VOTE, 0);
    `CHK("vote", 32'h0000_0804, rd)
    `CHK("guard", 4'hF, trip_b_n)
    apb(0, 8'h4C, 0);
    `CHK("slverr", 1'b1, err)
    $display("test reset done");
    apb(1, A_TIME, 0);
    apb(1, A_VOTE, 32'h0000_0403);
    frame(1); frame(1); frame(0);
    `CHK("thr", 8'hBF, disc_thr)
    `CHK("two of four", 1'b0, trip_a[0])
    frame(1);
    `CHK("three of four", 1'b1, trip_a[0])
    `CHK("path b", 1'b0, trip_b_n[0])
    frame(0);
    `CHK("slide", 1'b0, trip_a[0])
    $display("test vote done");
    code <= 16'h4321;
    apb(1, A_IDENT, 32'h0005_1234);
    apb(1, A_CTRL, 32'h20);
    repeat (3) frame(1);
    `CHK("id blocked", 1'b0, trip_a[0])
    repeat (4) frame(0);
    code <= 16'h1234;
    repeat (3) frame(1);
    `CHK("id ok", 1'b1, trip_a[0])
    $display("test identity done");
    stuck <= 1'b1;
    repeat (12) @(posedge pclk);
    `CHK("stuck guard", 1'b0, trip_a[0])
    apb(0, A_STAT, 0);
    `CHK("fault", 1'b1, rd[4])
    apb(1, A_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("relay", 1'b1, relay[0])
    stuck <= 1'b0;
    repeat (4) frame(0);
    apb(1, A_STAT, 32'h10);
    apb(0, A_STAT, 0);
    `CHK("fault clear", 1'b0, rd[4])
    `CHK("relay off", 1'b0, relay[0])
    $display("test selftest done");
    apb(1, A_TIME, 32'h2);
    trip_in <= 4'h2;
    repeat (20) @(posedge pclk);
    trip_in <= 4'h0;
    repeat (10) @(posedge pclk);
    `CHK("spike", 1'b0, tx_cmd[1])
    trip_in <= 4'h2;
    repeat (60) @(posedge pclk);
    `CHK("debounced", 1'b1, tx_cmd[1])
    trip_in <= 4'h0;
    repeat (5) @(posedge pclk);
    `CHK("no extend", 1'b0, tx_cmd[1])
    apb(0, A_CNT, 0);
    `CHK("count", 32'h0001_0000, rd)
    $display("test debounce done");
    peer_req <= 1'b1;
    peer_op <= 8'h10;
    @(posedge pclk);
    peer_req <= 1'b0;
    apb(0, A_STAT, 0);
    `CHK("refused", 1'b1, rd[10])
    peer_req <= 1'b1;
    peer_op <= 8'h0F;
    @(posedge pclk);
    peer_req <= 1'b0;
    @(negedge pclk);
    `CHK("exec", 1'b1, req_exec)
    @(posedge pclk);
    proc_ver <= 16'h0712;
    repeat (3) @(posedge pclk);
    `CHK("ver adj", 16'h0599, proc_ver_adj)
    proc_ver <= 16'h0433;
    repeat (3) @(posedge pclk);
    `CHK("ver keep", 16'h0433, proc_ver_adj)
    $display("test peer done");
    apb(1, A_CTRL, 32'h1);
    repeat (3) begin
      tone <= 3'h5;
      @(posedge pclk);
      tone <= 3'h0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
    `CHK("tone vote", 1'b1, trip_a[0])
    for (int i = 0; i < 4; i++) begin
      apb(1, A_CTRL, 32'(i) << 1);
      @(posedge pclk);
      `CHK("dig mode", i[1:0], link_cfg.dig)
    end
    for (int i = 0; i < 3; i++) begin
      apb(1, A_CTRL, 32'(i) << 3);
      @(posedge pclk);
      `CHK("tone mode", i[1:0], link_cfg.tmode)
    end
    $display("test modes done");
    tally_and_finish();
  end
endmodule : tcs_top_test
